// file: src/analog_out_pkg.sv
// constants shared by the output-mode register block and its helpers
// assumes a single 40 MHz clock domain with synchronous reset
package analog_out_pkg;
    // register offsets, base relative
    localparam logic [3:0] OFS_DMA_CLEAR = 4'h0;
    localparam logic [3:0] OFS_CONFIG    = 4'h4;
    localparam logic [3:0] OFS_IRQ2_CLR  = 4'h4;
    // field positions in output_mode_config
    localparam int CFG_SCAN    = 0;
    localparam int CFG_REF     = 1;
    localparam int CFG_LOW_OE  = 2;
    localparam int CFG_HIGH_OE = 3;
    localparam int CFG_CLK_IN  = 4;
    localparam int CFG_CLK_OUT = 5;
    localparam int CFG_DMA_STY = 6;
    localparam int CFG_WIDTH   = 7;
    localparam logic [CFG_WIDTH-1:0] CFG_RESET = 7'h00;
    // positions of the pins inside the synchroniser vector
    localparam int SYN_EXT    = 0;
    localparam int SYN_CNT2   = 1;
    localparam int SYN_HALF   = 2;
    localparam int SYN_ACK    = 3;
    localparam int SYN_UPD    = 4;
    localparam int SYN_DIO    = 5;
    localparam int SYN_WIDTH  = 13;
    // resting pin levels: the active-low pins idle high, so reset must not fake an edge
    localparam logic [SYN_WIDTH-1:0] SYN_IDLE = 13'h001d;
    localparam int DAC_WIDTH  = 16;
    localparam int CH_WIDTH   = 4;
    // sequencer states
    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b001,
        SEQ_FILL = 3'b010,
        SEQ_HOLD = 3'b100
    } seq_state_e;
endpackage : analog_out_pkg

// file: src/scan_if.sv
// signals between the register block and the channel sequencer
// assumes both ends run on the same clock
`timescale 1ns/100ps
`default_nettype none
interface scan_if;
    logic                                   scan_enable;
    logic                                   fifo_enable;
    logic [analog_out_pkg::CH_WIDTH-1:0]    last_channel;
    logic                                   update_rise;
    logic                                   update_fall;
    logic                                   fifo_valid;
    logic [analog_out_pkg::DAC_WIDTH-1:0]   fifo_data;
    logic                                   fifo_pop;
    logic                                   dac_write;
    logic [analog_out_pkg::CH_WIDTH-1:0]    dac_channel;
    logic [analog_out_pkg::DAC_WIDTH-1:0]   dac_data;
    logic                                   dac_load;
    modport ctrl (output scan_enable, fifo_enable, last_channel, update_rise, update_fall,
                  fifo_valid, fifo_data, input fifo_pop, dac_write, dac_channel, dac_data, dac_load);
    modport seq (input scan_enable, fifo_enable, last_channel, update_rise, update_fall,
                 fifo_valid, fifo_data, output fifo_pop, dac_write, dac_channel, dac_data, dac_load);
endinterface : scan_if
`default_nettype wire

// file: src/pin_sync.sv
// two-stage synchroniser with edge pulses for a vector of pins
// assumes pins are asynchronous to clk_i
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
    parameter int               WIDTH = 1,
    // resting level of each pin, so no false edge follows reset
    parameter logic [WIDTH-1:0] IDLE  = '0
) (
    input  wire logic             clk_i,
    input  wire logic             reset_i,
    input  wire logic [WIDTH-1:0] pin_i,
    output logic      [WIDTH-1:0] level_o,
    output logic      [WIDTH-1:0] rise_o,
    output logic      [WIDTH-1:0] fall_o
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
        logic [WIDTH-1:0] prev;
    } sync_s;
    sync_s state;
    sync_s next_state;

    // meta is only ever read by sync
    always_comb begin
        next_state.meta = pin_i;
        next_state.sync = state.meta;
        next_state.prev = state.sync;
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state <= {IDLE, IDLE, IDLE};
        end else begin
            state <= next_state;
        end
    end

    // edge detect per pin
    for (genvar i = 0; i < WIDTH; i++) begin : g_edge
        assign rise_o[i] = state.sync[i] & ~state.prev[i];
        assign fall_o[i] = ~state.sync[i] & state.prev[i];
    end
    assign level_o = state.sync;
endmodule : pin_sync
`default_nettype wire

// file: src/scan_sequencer.sv
// moves fifo words into dac channels, single channel or scanned
// assumes update edges arrive already synchronised
`timescale 1ns/100ps
`default_nettype none
module scan_sequencer (
    input  wire logic clk_i,
    input  wire logic reset_i,
    scan_if.seq       link
);
    typedef struct packed {
        analog_out_pkg::seq_state_e                 fsm;
        logic [analog_out_pkg::CH_WIDTH-1:0]        ch;
        logic                                       pop;
        logic                                       wr;
        logic                                       load;
        logic [analog_out_pkg::DAC_WIDTH-1:0]       data;
    } seq_s;
    seq_s state;
    seq_s next_state;
    logic take;

    // a word is taken at most every other cycle, the pop retires it
    assign take = link.fifo_valid && !state.pop;

    always_comb begin
        next_state      = state;
        next_state.pop  = 1'b0;
        next_state.wr   = 1'b0;
        next_state.load = 1'b0;
        if (!link.scan_enable) begin
            next_state.fsm = analog_out_pkg::SEQ_IDLE;
            if (link.fifo_enable && take) begin
                next_state.pop  = 1'b1;
                next_state.wr   = 1'b1;
                next_state.ch   = link.last_channel;
                next_state.data = link.fifo_data;
            end
        end else begin
            case (state.fsm)
                analog_out_pkg::SEQ_IDLE: begin
                    if (link.update_rise) begin
                        next_state.fsm = analog_out_pkg::SEQ_FILL;
                        next_state.ch  = '0;
                    end
                end
                analog_out_pkg::SEQ_FILL: begin
                    if (take) begin
                        next_state.pop  = 1'b1;
                        next_state.wr   = 1'b1;
                        next_state.data = link.fifo_data;
                        next_state.ch   = state.ch;
                        if (state.ch == link.last_channel) begin
                            next_state.fsm = analog_out_pkg::SEQ_HOLD;
                        end
                    end
                    if (state.wr && state.fsm == analog_out_pkg::SEQ_FILL) begin
                        next_state.ch = state.ch + 4'h1;
                    end
                end
                analog_out_pkg::SEQ_HOLD: begin
                    if (link.update_fall) begin
                        next_state.load = 1'b1;
                    end
                    if (link.update_rise) begin
                        next_state.fsm = analog_out_pkg::SEQ_FILL;
                        next_state.ch  = '0;
                    end
                end
                default: next_state.fsm = analog_out_pkg::SEQ_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state     <= '0;
            state.fsm <= analog_out_pkg::SEQ_IDLE;
        end else begin
            state <= next_state;
        end
    end

    assign link.fifo_pop    = state.pop;
    assign link.dac_write   = state.wr;
    assign link.dac_channel = state.ch;
    assign link.dac_data    = state.data;
    assign link.dac_load    = state.load;
endmodule : scan_sequencer
`default_nettype wire

// file: src/output_mode_regs.sv
// write-only output-mode register bank of a multi-channel analog board
// assumes a word-wide host write strobe on clk_i, async pins synchronised here
`timescale 1ns/100ps
`default_nettype none
module output_mode_regs #(
    parameter int CHANNELS = 10
) (
    input  wire logic                                   clk_i,
    input  wire logic                                   reset_i,
    // host write port
    input  wire logic                                   bus_write_i,
    input  wire logic                                   bus_word16_i,
    input  wire logic [3:0]                             bus_offset_i,
    input  wire logic [15:0]                            bus_wdata_i,
    // settings held elsewhere on the board
    input  wire logic                                   group2_write_select_i,
    input  wire logic                                   counter2_irq_enable_i,
    input  wire logic                                   ext_irq_enable_i,
    input  wire logic                                   dma_enable_bit_i,
    input  wire logic                                   fifo_enable_i,
    input  wire logic [analog_out_pkg::CH_WIDTH-1:0]    channel_select_field_i,
    // same-clock fifo and dma controller
    input  wire logic                                   dma_tc_i,
    input  wire logic                                   fifo_full_i,
    input  wire logic                                   fifo_valid_i,
    input  wire logic [analog_out_pkg::DAC_WIDTH-1:0]   fifo_data_i,
    input  wire logic                                   dio_write_i,
    input  wire logic [7:0]                             dio_wdata_i,
    // asynchronous pins
    input  wire logic                                   ext_update_input_n_i,
    input  wire logic                                   counter2_out_i,
    input  wire logic                                   fifo_half_flag_n_i,
    input  wire logic                                   dma_ack_n_i,
    input  wire logic                                   update_n_i,
    input  wire logic [7:0]                             dio_pin_i,
    // outputs
    output logic                                        dma_request_o,
    output logic                                        irq2_o,
    output logic                                        dma_irq_status_o,
    output logic                                        internal_ext_update_o,
    output logic                                        timing_clock_oe_o,
    output logic                                        timing_clock_select_o,
    output logic                                        reference_output_enable_o,
    output logic [7:0]                                  dio_pin_o,
    output logic [7:0]                                  dio_pin_oe_o,
    output logic [7:0]                                  dio_read_o,
    output logic                                        fifo_pop_o,
    output logic                                        dac_write_o,
    output logic [analog_out_pkg::CH_WIDTH-1:0]         dac_channel_o,
    output logic [analog_out_pkg::DAC_WIDTH-1:0]        dac_data_o,
    output logic                                        dac_load_o
);
    // the channel field is four bits wide
    if (CHANNELS < 1 || CHANNELS > 16) begin : g_bad_channels
        $error("CHANNELS must lie between 1 and 16");
    end

    typedef struct packed {
        logic [analog_out_pkg::CFG_WIDTH-1:0] cfg;
        logic       irq2;
        logic       dma_irq;
        logic       dma_req;
        logic       int_ext;
        logic [7:0] dio_out;
        logic [7:0] dio_oe;
        logic [7:0] dio_rd;
    } regs_s;
    regs_s state;
    regs_s next_state;

    logic [analog_out_pkg::SYN_WIDTH-1:0] pin_raw;
    logic [analog_out_pkg::SYN_WIDTH-1:0] pin_lvl;
    logic [analog_out_pkg::SYN_WIDTH-1:0] pin_rise;
    logic [analog_out_pkg::SYN_WIDTH-1:0] pin_fall;
    logic write_ok;
    logic cfg_hit;
    logic irq2_clr;
    logic dma_clr;
    logic irq2_set;
    logic dma_set;
    logic req_next;

    scan_if link ();

    // every asynchronous pin passes two flip-flops first
    assign pin_raw = {dio_pin_i, update_n_i, dma_ack_n_i, fifo_half_flag_n_i,
                      counter2_out_i, ext_update_input_n_i};

    pin_sync #(
        .WIDTH (analog_out_pkg::SYN_WIDTH),
        .IDLE  (analog_out_pkg::SYN_IDLE)
    ) u_sync (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .pin_i   (pin_raw),
        .level_o (pin_lvl),
        .rise_o  (pin_rise),
        .fall_o  (pin_fall)
    );

    assign write_ok = bus_write_i && bus_word16_i;

    assign cfg_hit  = write_ok && !group2_write_select_i
                      && bus_offset_i == analog_out_pkg::OFS_CONFIG;
    assign irq2_clr = write_ok && group2_write_select_i
                      && bus_offset_i == analog_out_pkg::OFS_IRQ2_CLR;
    assign dma_clr  = write_ok && group2_write_select_i
                      && bus_offset_i == analog_out_pkg::OFS_DMA_CLEAR;

    assign irq2_set = (counter2_irq_enable_i && pin_rise[analog_out_pkg::SYN_CNT2])
                      || (ext_irq_enable_i && pin_fall[analog_out_pkg::SYN_EXT]);

    assign dma_set = dma_enable_bit_i ? dma_tc_i
                                      : pin_fall[analog_out_pkg::SYN_HALF];

    // request style from the configuration
    always_comb begin
        req_next = 1'b0;
        if (dma_enable_bit_i) begin
            req_next = !fifo_full_i;
            if (state.cfg[analog_out_pkg::CFG_DMA_STY] && !pin_lvl[analog_out_pkg::SYN_ACK]) begin
                req_next = 1'b0;
            end
        end
    end

    // next register state; a set always wins over a clear in the same cycle
    always_comb begin
        next_state = state;
        if (cfg_hit) begin
            next_state.cfg = bus_wdata_i[analog_out_pkg::CFG_WIDTH-1:0];
        end
        if (irq2_clr) begin
            next_state.irq2 = 1'b0;
        end
        if (irq2_set) begin
            next_state.irq2 = 1'b1;
        end
        if (dma_clr) begin
            next_state.dma_irq = 1'b0;
        end
        if (dma_set) begin
            next_state.dma_irq = 1'b1;
        end
        next_state.dma_req = req_next;
        next_state.int_ext = !pin_lvl[analog_out_pkg::SYN_EXT];
        if (dio_write_i) begin
            next_state.dio_out = dio_wdata_i;
        end
        next_state.dio_oe[7:4] = {4{state.cfg[analog_out_pkg::CFG_HIGH_OE]}};
        next_state.dio_oe[3:0] = {4{state.cfg[analog_out_pkg::CFG_LOW_OE]}};
        next_state.dio_rd = pin_lvl[analog_out_pkg::SYN_DIO +: 8];
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state <= '0;
            state.cfg <= analog_out_pkg::CFG_RESET;
        end else begin
            state <= next_state;
        end
    end

    // hand the scan settings and update edges to the sequencer
    assign link.scan_enable  = state.cfg[analog_out_pkg::CFG_SCAN];
    assign link.fifo_enable  = fifo_enable_i;
    assign link.last_channel = channel_select_field_i;
    assign link.update_rise  = pin_rise[analog_out_pkg::SYN_UPD];
    assign link.update_fall  = pin_fall[analog_out_pkg::SYN_UPD];
    assign link.fifo_valid   = fifo_valid_i;
    assign link.fifo_data    = fifo_data_i;

    scan_sequencer u_seq (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .link    (link.seq)
    );

    // outputs straight from flip-flops
    assign dma_request_o             = state.dma_req;
    assign irq2_o                    = state.irq2;
    assign dma_irq_status_o          = state.dma_irq;
    assign internal_ext_update_o     = state.int_ext;
    assign timing_clock_oe_o         = state.cfg[analog_out_pkg::CFG_CLK_OUT];
    assign timing_clock_select_o     = state.cfg[analog_out_pkg::CFG_CLK_IN];
    assign reference_output_enable_o = state.cfg[analog_out_pkg::CFG_REF];
    assign dio_pin_o                 = state.dio_out;
    assign dio_pin_oe_o              = state.dio_oe;
    assign dio_read_o                = state.dio_rd;
    assign fifo_pop_o                = link.fifo_pop;
    assign dac_write_o               = link.dac_write;
    assign dac_channel_o             = link.dac_channel;
    assign dac_data_o                = link.dac_data;
    assign dac_load_o                = link.dac_load;

    // checks on the registered behaviour
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    AST_CFG_WRITE:
    assert property (cfg_hit |=> timing_clock_oe_o == $past(bus_wdata_i[5])
                     && reference_output_enable_o == $past(bus_wdata_i[1]))
        else $error("config write not stored");

    AST_SHORT_WRITE:
    assert property (bus_write_i && !bus_word16_i |=> $stable(state.cfg))
        else $error("byte write changed config");

    AST_IRQ2_CLEAR:
    assert property (irq2_clr && !irq2_set |=> !irq2_o)
        else $error("interrupt 2 not cleared");

    AST_IRQ2_SET:
    assert property (irq2_set |=> irq2_o)
        else $error("interrupt 2 event lost");

    AST_EXT_EDGE:
    assert property (pin_fall[analog_out_pkg::SYN_EXT] |=> $rose(internal_ext_update_o))
        else $error("no internal update rise");

    AST_DMA_SET:
    assert property (dma_enable_bit_i && dma_tc_i |=> dma_irq_status_o)
        else $error("terminal count lost");

    AST_DMA_HOLD:
    assert property (dma_irq_status_o && !dma_clr |=> dma_irq_status_o)
        else $error("dma interrupt fell without clear");

    AST_DMA_CLEAR:
    assert property (dma_clr && !dma_set |=> !dma_irq_status_o)
        else $error("dma interrupt not cleared");

    AST_REQ_CONT:
    assert property (dma_enable_bit_i && !state.cfg[analog_out_pkg::CFG_DMA_STY]
                     && !fifo_full_i |=> dma_request_o)
        else $error("request dropped before full");

    AST_REQ_FULL:
    assert property (fifo_full_i |=> !dma_request_o)
        else $error("request while full");

    AST_REQ_ACK:
    assert property (state.cfg[analog_out_pkg::CFG_DMA_STY]
                     && !pin_lvl[analog_out_pkg::SYN_ACK] |=> !dma_request_o)
        else $error("request high during acknowledge");

    AST_HIGH_NIBBLE:
    assert property (state.cfg[analog_out_pkg::CFG_HIGH_OE] |=> dio_pin_oe_o[7:4] == 4'hf)
        else $error("upper nibble not driven");

    AST_LOW_NIBBLE:
    assert property (!state.cfg[analog_out_pkg::CFG_LOW_OE] |=> dio_pin_oe_o[3:0] == 4'h0)
        else $error("lower nibble driven as input");

    AST_READBACK:
    assert property (1'b1 |=> dio_read_o == $past(pin_lvl[analog_out_pkg::SYN_DIO +: 8]))
        else $error("port read not pin level");

    AST_SINGLE_CH:
    assert property (dac_write_o && !$past(state.cfg[analog_out_pkg::CFG_SCAN])
                     |-> dac_channel_o == $past(channel_select_field_i))
        else $error("single mode wrote wrong channel");

    AST_SCAN_LIMIT:
    assert property (dac_write_o && $past(state.cfg[analog_out_pkg::CFG_SCAN])
                     |-> dac_channel_o <= $past(channel_select_field_i))
        else $error("scan passed the last channel");

    AST_CLK_SEL:
    assert property (cfg_hit |=> timing_clock_select_o == $past(bus_wdata_i[analog_out_pkg::CFG_CLK_IN]))
        else $error("clock input select not stored");

    AST_REF_HOLD:
    assert property (!cfg_hit |=> $stable(reference_output_enable_o))
        else $error("reference enable moved without write");

    AST_STROBE_CFG:
    assert property (irq2_clr || dma_clr |=> $stable(state.cfg))
        else $error("clear strobe changed config");

    AST_IRQ2_HOLD:
    assert property (irq2_o && !irq2_clr |=> irq2_o)
        else $error("interrupt 2 fell without clear");

    AST_DMA_HALF:
    assert property (!dma_enable_bit_i && pin_fall[analog_out_pkg::SYN_HALF] |=> dma_irq_status_o)
        else $error("half flag event lost");

    AST_LOAD_EDGE:
    assert property (dac_load_o |-> $past(link.update_fall))
        else $error("load without update pulse");

    AST_SINGLE_FIFO:
    assert property (dac_write_o && !$past(state.cfg[analog_out_pkg::CFG_SCAN]) |-> $past(fifo_enable_i))
        else $error("single write with fifo off");

    AST_HIGH_IN:
    assert property (!state.cfg[analog_out_pkg::CFG_HIGH_OE] |=> dio_pin_oe_o[7:4] == 4'h0)
        else $error("upper nibble driven as input");

    AST_LOW_OUT:
    assert property (state.cfg[analog_out_pkg::CFG_LOW_OE] |=> dio_pin_oe_o[3:0] == 4'hf)
        else $error("lower nibble not driven");

    AST_RESET_CFG:
    assert property (disable iff (1'b0) reset_i |=> state.cfg == analog_out_pkg::CFG_RESET
                     && dio_pin_oe_o == 8'h00)
        else $error("reset left config set");
endmodule : output_mode_regs
`default_nettype wire

// file: test/host_model.sv
// host side model: issues word writes, or short writes when w is low, to the register bank
// assumes the bench calls wr from one process in step with clk_i
`timescale 1ns/100ps
`default_nettype none
module host_model (
    input  wire logic        clk_i,
    output logic             wr_o,
    output logic             w16_o,
    output logic             sel_o,
    output logic [3:0]       ofs_o,
    output logic [15:0]      dat_o
);
    initial begin
        {wr_o, w16_o, sel_o, ofs_o, dat_o} = '0;
    end
    // strobe raised after a falling edge, dropped at the next one
    task automatic wr(input logic s, input logic [3:0] o, input logic [15:0] d, input logic w = 1'b1);
        @(negedge clk_i);
        {sel_o, ofs_o, w16_o, wr_o} = {s, o, w, 1'b1};
        dat_o = (!s && o == 4'h4) ? (d & (d[5] ? 16'h006f : 16'h007f)) : d;
        @(negedge clk_i);
        wr_o = 1'b0;
        dat_o = ~dat_o; // a released bus does not keep its last value
    endtask : wr
endmodule : host_model
`default_nettype wire

// file: test/output_mode_regs_tb_top.sv
// self-checking bench for the output-mode register bank
// assumes host_model drives the write port; the bench plays pins and fifo
`timescale 1ns/100ps
`default_nettype none
module output_mode_regs_tb_top;
    logic clk_i = 0, reset_i = 1, wr, w16, sel, c2en = 0, exen = 0, dma_enable_bit = 0, fen = 0, tc = 0, full = 0;
    logic valid = 0, dwr = 0, extn = 1, c2 = 0, halfn = 1, ackn = 1, updn = 1;
    logic req, irq2, dirq, ieu, coe, csel, refen, pop, dw, dld;
    logic [3:0] ofs, chsel = 4'h0, dch;
    logic [15:0] dat, fdat = 16'h0000, dd, d, s;
    logic [7:0] dwd = 8'h00, pins = 8'h00, dpo, doe, drd, pinw;
    logic [6:0] e;
    logic [31:0] seed = 32'he2da38d8;
    logic [3:0] chq[$];
    logic [15:0] dq[$];
    int bad_count = 0, n_checks = 0, cyc = 0, loads = 0;
    // pins driven by the bank win over the outside level
    assign pinw = (doe & dpo) | (~doe & pins);
    host_model host (.clk_i(clk_i), .wr_o(wr), .w16_o(w16), .sel_o(sel), .ofs_o(ofs), .dat_o(dat));
    output_mode_regs #(.CHANNELS(10)) DUT (.clk_i(clk_i), .reset_i(reset_i), .bus_write_i(wr),
        .bus_word16_i(w16), .bus_offset_i(ofs), .bus_wdata_i(dat), .group2_write_select_i(sel),
        .counter2_irq_enable_i(c2en), .ext_irq_enable_i(exen), .dma_enable_bit_i(dma_enable_bit), .fifo_enable_i(fen),
        .channel_select_field_i(chsel), .dma_tc_i(tc), .fifo_full_i(full), .fifo_valid_i(valid),
        .fifo_data_i(fdat), .dio_write_i(dwr), .dio_wdata_i(dwd), .ext_update_input_n_i(extn),
        .counter2_out_i(c2), .fifo_half_flag_n_i(halfn), .dma_ack_n_i(ackn), .update_n_i(updn),
        .dio_pin_i(pinw), .dma_request_o(req), .irq2_o(irq2), .dma_irq_status_o(dirq),
        .internal_ext_update_o(ieu), .timing_clock_oe_o(coe), .timing_clock_select_o(csel),
        .reference_output_enable_o(refen), .dio_pin_o(dpo), .dio_pin_oe_o(doe), .dio_read_o(drd),
        .fifo_pop_o(pop), .dac_write_o(dw), .dac_channel_o(dch), .dac_data_o(dd), .dac_load_o(dld));
    always #12.5 clk_i = ~clk_i;
    // record dac traffic; the fifo source advances on each pop
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (dw === 1'b1) begin
            chq.push_back(dch);
            dq.push_back(dd);
        end
        if (dld === 1'b1) loads <= loads + 1;
        if (pop === 1'b1) fdat <= fdat + 16'h0001;
        if (cyc == 3000) begin
            bad_count++;
            test_done();
        end
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic cy(input int n);
        repeat (n) @(negedge clk_i);
    endtask : cy
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // walk the recorded words: channel order and consecutive data
    task automatic seq_chk(input int n, input logic scan);
        chk(chq.size(), n);
        for (int i = 0; i < chq.size() && i < n; i++) begin
            chk(chq[i], scan ? i % (chsel + 1) : chsel);
            chk(dq[i], s + i);
        end
    endtask : seq_chk
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : test_done
    initial begin
        cy(4);
        reset_i = 0;
        chk({coe, csel, refen, doe, irq2, dirq, req}, 16'h0000);
        // corner of all ones first, then random settings and port traffic
        for (int i = 0; i < 8; i++) begin
            d = (i == 0) ? 16'hffff : rnd();
            {pins, dwd} = rnd();
            dwr = 1;
            cy(1);
            dwr = 0;
            host.wr(1'b0, 4'h4, d);
            cy(4);
            e = d[5] ? d[6:0] & 7'h6f : d[6:0];
            chk({coe, csel, refen}, {e[5], e[4], e[1]});
            chk(doe, {{4{e[3]}}, {4{e[2]}}});
            chk(drd, ({{4{e[3]}}, {4{e[2]}}} & dwd) | (~{{4{e[3]}}, {4{e[2]}}} & pins));
        end
        host.wr(1'b0, 4'h4, 16'h0000, 1'b0);
        host.wr(1'b0, 4'h2, 16'h0000);
        cy(2);
        chk({coe, csel, refen}, {e[5], e[4], e[1]});
        $display("test config done");
        host.wr(1'b0, 4'h4, 16'h0000);
        dma_enable_bit = 1;
        cy(2);
        chk(req, 1);
        full = 1;
        cy(2);
        chk(req, 0);
        full = 0;
        host.wr(1'b0, 4'h4, 16'h0040);
        ackn = 0;
        cy(5);
        chk(req, 0);
        ackn = 1;
        cy(5);
        chk(req, 1);
        tc = 1;
        cy(1);
        tc = 0;
        cy(4);
        chk(dirq, 1);
        host.wr(1'b1, 4'h0, rnd());
        cy(1);
        chk(dirq, 0);
        dma_enable_bit = 0;
        halfn = 0;
        cy(5);
        chk(dirq, 1);
        host.wr(1'b1, 4'h0, rnd());
        cy(1);
        chk(dirq, 0);
        $display("test dma done");
        c2en = 1;
        c2 = 1;
        cy(5);
        chk(irq2, 1);
        host.wr(1'b1, 4'h4, rnd());
        cy(1);
        chk(irq2, 0);
        {c2en, exen, extn} = 3'b010;
        cy(5);
        chk({ieu, irq2}, 2'b11);
        host.wr(1'b1, 4'h4, rnd());
        cy(1);
        chk({irq2, coe, refen}, 3'b000);
        $display("test irq2 done");
        // channel 9 takes -1000 so its current is off while the reference is on
        {fen, chsel, s} = {1'b1, 4'h9, 16'hfc18};
        host.wr(1'b0, 4'h4, 16'h0002);
        fdat = s;
        valid = 1;
        cy(6);
        valid = 0;
        cy(3);
        seq_chk(3, 0);
        chk(refen, 1);
        $display("test single done");
        chsel = 4'h2;
        s = rnd();
        host.wr(1'b0, 4'h4, 16'h0001);
        chq.delete();
        dq.delete();
        {fdat, valid, updn} = {s, 1'b1, 1'b0};
        cy(4);
        updn = 1;
        cy(20);
        seq_chk(3, 1);
        chk(loads, 0);
        updn = 0;
        cy(5);
        chk(loads, 1);
        updn = 1;
        cy(20);
        seq_chk(6, 1);
        $display("test scan done");
        test_done();
    end
endmodule : output_mode_regs_tb_top
`default_nettype wire
